//--- hw/overlay_plane_cfg.svh
// Purpose: Offsets, field positions and reset values of the overlay plane registers
// Assumes: Byte offsets within the display register space, 20-bit address
// Notes: Definitions only
`ifndef OVERLAY_PLANE_CFG_SVH
`define OVERLAY_PLANE_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_SIZE 20'h72190
`define OFS_KEY_VALUE 20'h72194
`define OFS_KEY_MASK 20'h72198
`define OFS_SURFACE 20'h7219c
`define OFS_KEY_MAXIMUM 20'h721a0
`define OFS_TILED_OFFSET 20'h721a4

// ************************************************************
// Field positions
// ************************************************************
`define FLD_UPPER 27:16
`define FLD_LOWER 11:0
`define FLD_BYTE2 23:16
`define FLD_BYTE1 15:8
`define FLD_BYTE0 7:0
`define FLD_SRC_EN_V 26
`define FLD_SRC_EN_Y 25
`define FLD_SRC_EN_U 24
`define FLD_SURF_PAGE 31:12

// ************************************************************
// Reset values
// ************************************************************
`define RST_WORD 32'h00000000
`define RST_PAGE_LOW 12'h000

`endif

//--- hw/overlay_plane_pkg.sv
// Purpose: Types shared by the overlay plane register bank and its key matcher
// Assumes: Constants live in overlay_plane_cfg.svh
// Notes: All structs are packed so they can be held and compared as vectors
package overlay_plane_pkg;

	// ************************************************************
	// Register fields
	// ************************************************************
	typedef struct packed {
		logic [11:0] height_m1;
		logic [11:0] width_m1;
	} plane_size_s;

	typedef struct packed {
		logic [7:0] v_r;
		logic [7:0] y_g;
		logic [7:0] u_b;
	} key_triple_s;

	typedef struct packed {
		logic en_v;
		logic en_y;
		logic en_u;
		key_triple_s dmask;
	} key_mask_s;

	typedef struct packed {
		logic [11:0] y;
		logic [11:0] x;
	} tile_offset_s;

	typedef struct packed {
		plane_size_s size;
		key_triple_s kval;
		key_mask_s kmsk;
		logic [19:0] surf;
		key_triple_s kmax;
		tile_offset_s toff;
	} regset_s;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_SIZE,
		SEL_KEY_VALUE,
		SEL_KEY_MASK,
		SEL_SURFACE,
		SEL_KEY_MAXIMUM,
		SEL_TILED_OFFSET
	} reg_sel_e;

	// ************************************************************
	// Module state
	// ************************************************************
	typedef struct packed {
		regset_s pend;
		regset_s act;
		logic armed;
		logic [31:0] rdata;
		logic rvalid;
		logic [12:0] width_px;
		logic [12:0] height_ln;
		logic [11:0] pan_x;
		logic [11:0] pan_y;
		logic pan_tiled;
		logic pan_lower_right;
	} geom_state_s;

	typedef struct packed {
		logic match;
		logic show_overlay;
		logic valid;
	} key_state_s;

endpackage

//--- hw/colour_key_match.sv
// Purpose: Source range and destination colour key compare for one overlay pixel
// Assumes: Key settings already latched; pixels on the display clock
// Notes: Result appears one clock after pixel_valid
`timescale 1ns/100ps
`default_nettype none
module colour_key_match (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Latched key settings
	input wire overlay_plane_pkg::key_triple_s key_value,
	input wire overlay_plane_pkg::key_triple_s key_maximum,
	input wire overlay_plane_pkg::key_mask_s key_mask,
	// Keying mode
	input wire logic src_key_en,
	input wire logic dst_key_en,
	// Pixels
	input wire overlay_plane_pkg::key_triple_s ovl_pixel,
	input wire overlay_plane_pkg::key_triple_s pri_pixel,
	input wire logic pixel_valid,
	// Result
	output logic key_match,
	output logic show_overlay,
	output logic key_valid
);

	overlay_plane_pkg::key_state_s st_reg;
	overlay_plane_pkg::key_state_s st_next;
	logic src_hit;
	logic dst_hit;

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// ************************************************************
	// Compare
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		src_hit = (!key_mask.en_v || in_range(ovl_pixel.v_r, key_value.v_r, key_maximum.v_r)) &&
			(!key_mask.en_y || in_range(ovl_pixel.y_g, key_value.y_g, key_maximum.y_g)) &&
			(!key_mask.en_u || in_range(ovl_pixel.u_b, key_value.u_b, key_maximum.u_b)); // R9 R10 R11 R22
		dst_hit = (((pri_pixel ^ key_value) & key_mask.dmask) == 24'h000000); // R9 R12
		st_next.valid = pixel_valid;
		st_next.match = dst_key_en ? dst_hit : (src_key_en && src_hit); // R10
		// A keyed-out overlay pixel lets the primary plane show through
		st_next.show_overlay = dst_key_en ? dst_hit : !(src_key_en && src_hit); // R21
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign key_match = st_reg.match;
	assign show_overlay = st_reg.show_overlay;
	assign key_valid = st_reg.valid;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_DST_COMPARE: assert property (@(posedge clock) disable iff (!rst_n) // R12
		dst_key_en |=> show_overlay == ((($past(pri_pixel) ^ $past(key_value)) &
		$past(key_mask.dmask)) == 24'h000000))
		else $error("destination key compare wrong");
	AST_SRC_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // R22
		(src_key_en && !dst_key_en && key_mask.en_y && (ovl_pixel.y_g < key_value.y_g))
		|=> !key_match && show_overlay)
		else $error("pixel below range matched");
	AST_MAX_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // R10
		(!src_key_en && !dst_key_en) |=> !key_match && show_overlay)
		else $error("key active with keying off");
	COV_DST_HIT: cover property (@(posedge clock) disable iff (!rst_n)
		dst_key_en ##1 show_overlay);
	COV_SRC_HIT: cover property (@(posedge clock) disable iff (!rst_n)
		src_key_en ##1 key_match);

endmodule // colour_key_match
`default_nettype wire

//--- hw/sprite_plane_geometry_key_regs.sv
// Purpose: Geometry, surface and colour key registers of one overlay plane
// Assumes: All inputs are on the display clock; vblank_start is a one-cycle pulse
// Notes: Pending copies are what software reads back; active copies drive the plane
//
// Functional notes
// R1: Height field is line count minus one
// R2: Width field is pixel count minus one
// R3: Software keeps width even for doubled/luma-chroma
// R4: Software keeps width within stride in pixels
// R5: Software keeps position plus width on screen
// R6: Size latches after arming, at blank or disable
// R7: Surface write arms the armed registers
// R8: Key, surface, tile latch at blank or pipe-off
// R9: Key value bytes are minimums or compare values
// R10: Key maximum only matters with source keying
// R11: Mask bits 26..24 enable per-channel range checks
// R12: Cleared destination mask bits ignore mismatches
// R13: Software never enables both keying modes
// R14: Software writes 4K aligned surface base
// R15: Surface base is an aperture page index
// R16: Tiled surfaces pan by tile offset, linear ignore it
// R17: Tile offset gives start line and pixel
// R18: Software keeps tiled x offset even
// R19: Rotation makes tile offset the lower-right corner
// R20: Surface base updated by writes and flips
// R21: Destination match shows overlay, else primary
// R22: Source match needs all enabled channels in range
// R23: Reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "overlay_plane_cfg.svh"
module sprite_plane_geometry_key_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register access
	input wire logic mmio_wr,
	input wire logic mmio_rd,
	input wire logic [19:0] mmio_addr,
	input wire logic [31:0] mmio_wdata,
	output logic [31:0] mmio_rdata,
	output logic mmio_rvalid,
	// Command streamer flip
	input wire logic flip_valid,
	input wire logic [31:0] flip_addr,
	// Pipe and plane status
	input wire logic vblank_start,
	input wire logic pipe_enabled,
	input wire logic plane_enabled,
	input wire logic tiled_surface,
	input wire logic rotate_180,
	input wire logic src_key_en,
	input wire logic dst_key_en,
	// Pixel path
	input wire overlay_plane_pkg::key_triple_s ovl_pixel,
	input wire overlay_plane_pkg::key_triple_s pri_pixel,
	input wire logic pixel_valid,
	// Geometry and surface
	output logic [12:0] width_px,
	output logic [12:0] height_ln,
	output logic [19:0] surface_page,
	output logic [11:0] pan_x,
	output logic [11:0] pan_y,
	output logic pan_tiled,
	output logic pan_lower_right,
	output logic size_armed,
	// Key result
	output logic key_match,
	output logic show_overlay,
	output logic key_valid
);

	// ************************************************************
	// State
	// ************************************************************
	overlay_plane_pkg::geom_state_s st_reg;
	overlay_plane_pkg::geom_state_s st_next;
	overlay_plane_pkg::reg_sel_e acc_sel;
	logic arm_event;
	logic key_update;
	logic size_update;

	function automatic overlay_plane_pkg::reg_sel_e decode(input logic [19:0] addr);
		case (addr)
			`OFS_SIZE: return overlay_plane_pkg::SEL_SIZE;
			`OFS_KEY_VALUE: return overlay_plane_pkg::SEL_KEY_VALUE;
			`OFS_KEY_MASK: return overlay_plane_pkg::SEL_KEY_MASK;
			`OFS_SURFACE: return overlay_plane_pkg::SEL_SURFACE;
			`OFS_KEY_MAXIMUM: return overlay_plane_pkg::SEL_KEY_MAXIMUM;
			`OFS_TILED_OFFSET: return overlay_plane_pkg::SEL_TILED_OFFSET;
			default: return overlay_plane_pkg::SEL_NONE;
		endcase
	endfunction

	function automatic logic [31:0] triple_word(input overlay_plane_pkg::key_triple_s t);
		logic [31:0] w;
		w = `RST_WORD;
		w[`FLD_BYTE2] = t.v_r;
		w[`FLD_BYTE1] = t.y_g;
		w[`FLD_BYTE0] = t.u_b;
		return w;
	endfunction

	function automatic logic [31:0] pair_word(input logic [11:0] hi, input logic [11:0] lo);
		logic [31:0] w;
		w = `RST_WORD;
		w[`FLD_UPPER] = hi;
		w[`FLD_LOWER] = lo;
		return w;
	endfunction

	function automatic overlay_plane_pkg::key_triple_s word_triple(input logic [31:0] w);
		overlay_plane_pkg::key_triple_s t;
		t.v_r = w[`FLD_BYTE2];
		t.y_g = w[`FLD_BYTE1];
		t.u_b = w[`FLD_BYTE0];
		return t;
	endfunction

	assign acc_sel = decode(mmio_addr);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		arm_event = 1'b0;
		// Pipe off makes the latch transparent so a mode set needs no blank
		key_update = vblank_start || !pipe_enabled; // R8
		size_update = st_reg.armed && (vblank_start || !pipe_enabled || !plane_enabled); // R6

		// Read back pending values; unmapped and reserved bits give zero
		st_next.rvalid = mmio_rd;
		st_next.rdata = `RST_WORD;
		if (mmio_rd) begin
			case (acc_sel)
				overlay_plane_pkg::SEL_SIZE: begin
					st_next.rdata = pair_word(st_reg.pend.size.height_m1,
						st_reg.pend.size.width_m1); // R23
				end
				overlay_plane_pkg::SEL_KEY_VALUE: begin
					st_next.rdata = triple_word(st_reg.pend.kval); // R23
				end
				overlay_plane_pkg::SEL_KEY_MASK: begin
					st_next.rdata = triple_word(st_reg.pend.kmsk.dmask);
					st_next.rdata[`FLD_SRC_EN_V] = st_reg.pend.kmsk.en_v;
					st_next.rdata[`FLD_SRC_EN_Y] = st_reg.pend.kmsk.en_y;
					st_next.rdata[`FLD_SRC_EN_U] = st_reg.pend.kmsk.en_u;
				end
				overlay_plane_pkg::SEL_SURFACE: begin
					st_next.rdata = {st_reg.pend.surf, `RST_PAGE_LOW}; // R23
				end
				overlay_plane_pkg::SEL_KEY_MAXIMUM: begin
					st_next.rdata = triple_word(st_reg.pend.kmax);
				end
				overlay_plane_pkg::SEL_TILED_OFFSET: begin
					st_next.rdata = pair_word(st_reg.pend.toff.y, st_reg.pend.toff.x);
				end
				default: begin
					st_next.rdata = `RST_WORD;
				end
			endcase
		end

		// A flip from the command streamer loads the base like a write
		if (flip_valid) begin
			st_next.pend.surf = flip_addr[`FLD_SURF_PAGE]; // R20
			arm_event = 1'b1; // R20
		end

		// Only defined fields are stored, so reserved bits have no effect
		if (mmio_wr) begin
			case (acc_sel)
				overlay_plane_pkg::SEL_SIZE: begin
					st_next.pend.size.height_m1 = mmio_wdata[`FLD_UPPER]; // R1
					st_next.pend.size.width_m1 = mmio_wdata[`FLD_LOWER]; // R2
				end
				overlay_plane_pkg::SEL_KEY_VALUE: begin
					st_next.pend.kval = word_triple(mmio_wdata); // R9
				end
				overlay_plane_pkg::SEL_KEY_MASK: begin
					st_next.pend.kmsk.en_v = mmio_wdata[`FLD_SRC_EN_V]; // R11
					st_next.pend.kmsk.en_y = mmio_wdata[`FLD_SRC_EN_Y]; // R11
					st_next.pend.kmsk.en_u = mmio_wdata[`FLD_SRC_EN_U]; // R11
					st_next.pend.kmsk.dmask = word_triple(mmio_wdata); // R12
				end
				overlay_plane_pkg::SEL_SURFACE: begin
					st_next.pend.surf = mmio_wdata[`FLD_SURF_PAGE]; // R15
					arm_event = 1'b1; // R7
				end
				overlay_plane_pkg::SEL_KEY_MAXIMUM: begin
					st_next.pend.kmax = word_triple(mmio_wdata); // R10
				end
				overlay_plane_pkg::SEL_TILED_OFFSET: begin
					st_next.pend.toff.y = mmio_wdata[`FLD_UPPER]; // R17
					st_next.pend.toff.x = mmio_wdata[`FLD_LOWER]; // R17
				end
				default: begin
					st_next.pend = st_next.pend;
				end
			endcase
		end

		// Unarmed registers follow their pending copy at each update point
		if (key_update) begin
			st_next.act.kval = st_reg.pend.kval; // R8
			st_next.act.kmsk = st_reg.pend.kmsk; // R8
			st_next.act.kmax = st_reg.pend.kmax; // R8
			st_next.act.surf = st_reg.pend.surf; // R8
			st_next.act.toff = st_reg.pend.toff; // R8
		end

		// Size waits for arming; a fresh arm in the same cycle survives
		if (size_update) begin
			st_next.act.size = st_reg.pend.size; // R6
			st_next.armed = 1'b0;
		end
		if (arm_event) begin
			st_next.armed = 1'b1; // R7
		end

		// Outputs derived from the active copy and the tiled_surface and rotate_180 inputs
		st_next.width_px = {1'b0, st_next.act.size.width_m1} + 13'h0001; // R2
		st_next.height_ln = {1'b0, st_next.act.size.height_m1} + 13'h0001; // R1
		st_next.pan_tiled = tiled_surface; // R16
		st_next.pan_x = tiled_surface ? st_next.act.toff.x : 12'h000; // R16 R17
		st_next.pan_y = tiled_surface ? st_next.act.toff.y : 12'h000; // R16 R17
		st_next.pan_lower_right = tiled_surface && rotate_180; // R19
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign mmio_rdata = st_reg.rdata;
	assign mmio_rvalid = st_reg.rvalid;
	assign width_px = st_reg.width_px;
	assign height_ln = st_reg.height_ln;
	// Page index into the aperture; the translation table walk sits downstream
	assign surface_page = st_reg.act.surf; // R15
	assign pan_x = st_reg.pan_x;
	assign pan_y = st_reg.pan_y;
	assign pan_tiled = st_reg.pan_tiled;
	assign pan_lower_right = st_reg.pan_lower_right;
	assign size_armed = st_reg.armed;

	// ************************************************************
	// Key matcher
	// ************************************************************
	colour_key_match u_key (
		.clock(clock),
		.rst_n(rst_n),
		.key_value(st_reg.act.kval),
		.key_maximum(st_reg.act.kmax),
		.key_mask(st_reg.act.kmsk),
		.src_key_en(src_key_en),
		.dst_key_en(dst_key_en),
		.ovl_pixel(ovl_pixel),
		.pri_pixel(pri_pixel),
		.pixel_valid(pixel_valid),
		.key_match(key_match),
		.show_overlay(show_overlay),
		.key_valid(key_valid)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	AST_SIZE_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // R6
		!st_reg.armed |=> $stable(st_reg.act.size))
		else $error("size changed without arming");
	AST_SIZE_LATCH: assert property (@(posedge clock) disable iff (!rst_n) // R6
		(st_reg.armed && vblank_start) |=> st_reg.act.size == $past(st_reg.pend.size))
		else $error("armed size not latched at blank");
	AST_ARM: assert property (@(posedge clock) disable iff (!rst_n) // R7
		(mmio_wr && acc_sel == overlay_plane_pkg::SEL_SURFACE) |=> size_armed)
		else $error("surface write did not arm");
	AST_FLIP: assert property (@(posedge clock) disable iff (!rst_n) // R20
		(flip_valid && !(mmio_wr && acc_sel == overlay_plane_pkg::SEL_SURFACE))
		|=> size_armed && st_reg.pend.surf == $past(flip_addr[31:12]))
		else $error("flip not taken");
	AST_KEY_LATCH: assert property (@(posedge clock) disable iff (!rst_n) // R8
		vblank_start |=> st_reg.act.kval == $past(st_reg.pend.kval) &&
		st_reg.act.toff == $past(st_reg.pend.toff))
		else $error("key or tile offset not latched at blank");
	AST_KEY_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // R8
		(pipe_enabled && !vblank_start) |=> $stable(st_reg.act.kval) &&
		$stable(surface_page))
		else $error("active value moved outside update point");
	// Counts are registered from the active copy, so the first cycle out of reset is skipped
	AST_SIZE_COUNT: assert property (@(posedge clock) disable iff (!rst_n) // R1
		rst_n |=> height_ln == {1'b0, st_reg.act.size.height_m1} + 13'h0001 &&
		width_px == {1'b0, st_reg.act.size.width_m1} + 13'h0001)
		else $error("size count not value plus one");
	AST_RESERVED: assert property (@(posedge clock) disable iff (!rst_n) // R23
		(mmio_rd && acc_sel == overlay_plane_pkg::SEL_SIZE) |=>
		mmio_rvalid && mmio_rdata[31:28] == 4'h0 && mmio_rdata[15:12] == 4'h0)
		else $error("reserved size bits read nonzero");
	AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n) // R23
		(mmio_rd && acc_sel == overlay_plane_pkg::SEL_NONE) |=> mmio_rdata == 32'h00000000)
		else $error("unmapped read nonzero");
	AST_LINEAR_PAN: assert property (@(posedge clock) disable iff (!rst_n) // R16
		!tiled_surface |=> !pan_tiled && pan_x == 12'h000 && pan_y == 12'h000)
		else $error("tile offset used on linear surface");
	AST_ROTATE: assert property (@(posedge clock) disable iff (!rst_n) // R19
		(tiled_surface && rotate_180) |=> pan_lower_right)
		else $error("rotation corner flag missing");
	AST_ROTATE_OFF: assert property (@(posedge clock) disable iff (!rst_n) // R19
		!(tiled_surface && rotate_180) |=> !pan_lower_right)
		else $error("rotation corner flag without rotation");
	AST_TILE_PAN: assert property (@(posedge clock) disable iff (!rst_n) // R17
		tiled_surface |=> pan_tiled && pan_x == st_reg.act.toff.x &&
		pan_y == st_reg.act.toff.y)
		else $error("tiled pan not taken from active offset");
	AST_PIPE_OFF: assert property (@(posedge clock) disable iff (!rst_n) // R8
		!pipe_enabled |=> st_reg.act.kmsk == $past(st_reg.pend.kmsk) &&
		surface_page == $past(st_reg.pend.surf))
		else $error("pipe off did not pass pending values");
	AST_PLANE_OFF: assert property (@(posedge clock) disable iff (!rst_n) // R6
		(st_reg.armed && !plane_enabled) |=> st_reg.act.size == $past(st_reg.pend.size))
		else $error("armed size not latched with plane off");
	AST_SURF_LOW: assert property (@(posedge clock) disable iff (!rst_n) // R23
		(mmio_rd && acc_sel == overlay_plane_pkg::SEL_SURFACE) |=>
		mmio_rdata[11:0] == 12'h000)
		else $error("reserved surface bits read nonzero");
	AST_READ_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // R23
		!mmio_rd |=> !mmio_rvalid && mmio_rdata == 32'h00000000)
		else $error("read data outside a read answer");
	COV_ARMED_BLANK: cover property (@(posedge clock) disable iff (!rst_n)
		st_reg.armed && vblank_start);
	COV_FLIP: cover property (@(posedge clock) disable iff (!rst_n)
		flip_valid ##1 size_armed);
	COV_PIPE_OFF: cover property (@(posedge clock) disable iff (!rst_n)
		!pipe_enabled && st_reg.armed);

endmodule // sprite_plane_geometry_key_regs
`default_nettype wire

//--- bench/sprite_plane_geometry_key_regs_tb.sv
// Purpose: Self-checking bench for the overlay plane register bank
// Assumes: Bench drives every port itself; inputs change 1 ns after the rising edge
// Notes: Keying checks run with the pipe off so settings latch at once
`timescale 1ns/100ps
`default_nettype none
`include "overlay_plane_cfg.svh"
`define CHECK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
	$display("[FAIL] %s expected %h seen %h", name, exp, got); errors++; end end
module sprite_plane_geometry_key_regs_tb;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clock, rst_n, mmio_wr, mmio_rd, flip_valid, vblank_start, pipe_enabled;
	logic plane_enabled, tiled_surface, rotate_180, src_key_en, dst_key_en, pixel_valid;
	logic [19:0] mmio_addr;
	logic [31:0] mmio_wdata, mmio_rdata, flip_addr;
	logic mmio_rvalid, pan_tiled, pan_lower_right, size_armed, key_match, show_overlay, key_valid;
	logic [12:0] width_px, height_ln;
	logic [19:0] surface_page;
	logic [11:0] pan_x, pan_y;
	overlay_plane_pkg::key_triple_s ovl_pixel, pri_pixel;
	int errors = 0;
	int comparisons = 0;
	logic [19:0] reg_ofs [6] = '{`OFS_SIZE, `OFS_KEY_VALUE, `OFS_KEY_MASK, `OFS_SURFACE,
		`OFS_KEY_MAXIMUM, `OFS_TILED_OFFSET};
	// Writable bits per register; everything else is reserved
	logic [31:0] reg_msk [6] = '{32'h0fff0fff, 32'h00ffffff, 32'h07ffffff, 32'hfffff000,
		32'h00ffffff, 32'h0fff0fff};

	sprite_plane_geometry_key_regs DUT (
		.clock(clock), .rst_n(rst_n), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd),
		.mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata), .mmio_rdata(mmio_rdata),
		.mmio_rvalid(mmio_rvalid), .flip_valid(flip_valid), .flip_addr(flip_addr),
		.vblank_start(vblank_start), .pipe_enabled(pipe_enabled),
		.plane_enabled(plane_enabled), .tiled_surface(tiled_surface),
		.rotate_180(rotate_180), .src_key_en(src_key_en), .dst_key_en(dst_key_en),
		.ovl_pixel(ovl_pixel), .pri_pixel(pri_pixel), .pixel_valid(pixel_valid),
		.width_px(width_px), .height_ln(height_ln), .surface_page(surface_page),
		.pan_x(pan_x), .pan_y(pan_y), .pan_tiled(pan_tiled),
		.pan_lower_right(pan_lower_right), .size_armed(size_armed),
		.key_match(key_match), .show_overlay(show_overlay), .key_valid(key_valid)
	);

	// ************************************************************
	// Bus and pixel tasks
	// ************************************************************
	task automatic tick(input int n = 1);
		repeat (n) begin
			@(posedge clock);
			#1;
		end
	endtask

	// Extra idle cycle keeps a strobe from being lowered and raised in one time step
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		mmio_wr = 1'b1;
		mmio_addr = a;
		mmio_wdata = d;
		tick();
		mmio_wr = 1'b0;
		tick();
	endtask

	task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
		mmio_rd = 1'b1;
		mmio_addr = a;
		tick();
		mmio_rd = 1'b0;
		`CHECK("mmio_rvalid", 1'b1, mmio_rvalid)
		`CHECK("mmio_rdata", exp, mmio_rdata)
		tick();
	endtask

	task automatic vblank();
		vblank_start = 1'b1;
		tick();
		vblank_start = 1'b0;
		tick(2);
	endtask

	task automatic pix(input logic [23:0] o, input logic [23:0] p, input logic m, input logic s);
		ovl_pixel = o;
		pri_pixel = p;
		pixel_valid = 1'b1;
		tick();
		pixel_valid = 1'b0;
		`CHECK("key_valid", 1'b1, key_valid)
		`CHECK("key_match", m, key_match)
		`CHECK("show_overlay", s, show_overlay)
		tick();
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic regs_scn();
		for (int i = 0; i < 6; i++) rd_chk(reg_ofs[i], 32'h00000000);
		for (int i = 0; i < 6; i++) begin
			wr(reg_ofs[i], 32'hffffffff);
			rd_chk(reg_ofs[i], reg_msk[i]);
		end
		wr(20'h721a8, 32'hffffffff);
		rd_chk(20'h721a8, 32'h00000000);
	endtask

	task automatic arm_scn();
		vblank();
		`CHECK("width_px max", 13'h1000, width_px)
		`CHECK("height_ln max", 13'h1000, height_ln)
		`CHECK("surface_page", 20'hfffff, surface_page)
		`CHECK("size_armed clear", 1'b0, size_armed)
		wr(`OFS_SIZE, 32'h00090013);
		vblank();
		`CHECK("width_px unarmed", 13'h1000, width_px)
		wr(`OFS_SURFACE, 32'h00123000);
		`CHECK("size_armed set", 1'b1, size_armed)
		`CHECK("surface_page held", 20'hfffff, surface_page)
		vblank();
		`CHECK("width_px", 13'h0014, width_px)
		`CHECK("height_ln", 13'h000a, height_ln)
		`CHECK("surface_page new", 20'h00123, surface_page)
		// Disabling the plane latches an armed size without a blank
		wr(`OFS_SIZE, 32'h00010003);
		wr(`OFS_SURFACE, 32'h00123000);
		plane_enabled = 1'b0;
		tick(3);
		`CHECK("width_px plane off", 13'h0004, width_px)
		`CHECK("height_ln plane off", 13'h0002, height_ln)
		plane_enabled = 1'b1;
		tick();
	endtask

	task automatic flip_scn();
		flip_valid = 1'b1;
		flip_addr = 32'habcde123;
		tick();
		flip_valid = 1'b0;
		tick();
		`CHECK("size_armed flip", 1'b1, size_armed)
		rd_chk(`OFS_SURFACE, 32'habcde000);
		vblank();
		`CHECK("surface_page flip", 20'habcde, surface_page)
	endtask

	task automatic pan_scn();
		pipe_enabled = 1'b0;
		tiled_surface = 1'b1;
		wr(`OFS_TILED_OFFSET, 32'h01230456);
		tick(2);
		`CHECK("pan_x", 12'h456, pan_x)
		`CHECK("pan_y", 12'h123, pan_y)
		`CHECK("pan_tiled", 1'b1, pan_tiled)
		`CHECK("pan_lower_right off", 1'b0, pan_lower_right)
		rotate_180 = 1'b1;
		tick(2);
		`CHECK("pan_lower_right on", 1'b1, pan_lower_right)
		tiled_surface = 1'b0;
		tick(2);
		`CHECK("pan_x linear", 12'h000, pan_x)
		`CHECK("pan_y linear", 12'h000, pan_y)
		`CHECK("pan_tiled linear", 1'b0, pan_tiled)
		rotate_180 = 1'b0;
	endtask

	task automatic key_scn();
		// Pipe is still off, so key registers latch within two cycles
		dst_key_en = 1'b1;
		wr(`OFS_KEY_VALUE, 32'h00102030);
		wr(`OFS_KEY_MASK, 32'h00fff0ff);
		tick(2);
		pix(24'h000000, 24'h102030, 1'b1, 1'b1);
		pix(24'h000000, 24'h102730, 1'b1, 1'b1);
		pix(24'h000000, 24'h112030, 1'b0, 1'b0);
		pix(24'h000000, 24'h102031, 1'b0, 1'b0);
		dst_key_en = 1'b0;
		src_key_en = 1'b1;
		wr(`OFS_KEY_MAXIMUM, 32'h00405060);
		wr(`OFS_KEY_MASK, 32'h07000000);
		tick(2);
		pix(24'h102030, 24'h000000, 1'b1, 1'b0);
		pix(24'h405060, 24'h000000, 1'b1, 1'b0);
		pix(24'h405061, 24'h000000, 1'b0, 1'b1);
		pix(24'h10202f, 24'h000000, 1'b0, 1'b1);
		wr(`OFS_KEY_MASK, 32'h06000000);
		tick(2);
		pix(24'h4050ff, 24'h000000, 1'b1, 1'b0);
		pix(24'h0f5060, 24'h000000, 1'b0, 1'b1);
		pix(24'h401f60, 24'h000000, 1'b0, 1'b1);
		src_key_en = 1'b0;
		pix(24'h102030, 24'h102030, 1'b0, 1'b1);
	endtask

	// ************************************************************
	// Run control
	// ************************************************************
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Hang guard: the whole run needs far fewer cycles than this
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		end_sim();
	end

	initial begin
		rst_n = 1'b0;
		{mmio_wr, mmio_rd, flip_valid, vblank_start, pixel_valid} = '0;
		{tiled_surface, rotate_180, src_key_en, dst_key_en} = '0;
		pipe_enabled = 1'b1;
		plane_enabled = 1'b1;
		mmio_addr = 20'h00000;
		mmio_wdata = 32'h00000000;
		flip_addr = 32'h00000000;
		ovl_pixel = 24'h000000;
		pri_pixel = 24'h000000;
		repeat (12) @(posedge clock);
		#1;
		rst_n = 1'b1;
		tick();
		`CHECK("width_px reset", 13'h0001, width_px)
		`CHECK("height_ln reset", 13'h0001, height_ln)
		regs_scn();
		arm_scn();
		flip_scn();
		pan_scn();
		key_scn();
		end_sim();
	end
endmodule // sprite_plane_geometry_key_regs_tb
`default_nettype wire
